// *** rai_pkg.sv ***
// package: constants and types of the reset and interrupt arbiter
package rai_pkg;
	// clk_i is the fc clock itself, 250 MHz, 4 ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int FC_PER_CLK = 1;
	localparam int EXT_RST_TIME_FC = 12; // least pin low time, fc periods
	localparam int MALF_RST_TIME_FC = 24; // fault reset length, fc periods
	localparam int EXT_RST_CYC = (EXT_RST_TIME_FC + FC_PER_CLK - 1)
		/ FC_PER_CLK;
	localparam int MALF_RST_CYC = MALF_RST_TIME_FC / FC_PER_CLK;
	localparam logic [3:0] EXT_CNT_LAST = 4'(EXT_RST_CYC - 1);
	localparam logic [4:0] MALF_CNT_LOAD = 5'(MALF_RST_CYC);
	localparam logic [4:0] MALF_CNT_ONE = 5'h01;

	// register byte offsets on the wishbone slave
	localparam logic [7:0] REG_ENABLE = 8'h00;
	localparam logic [7:0] REG_LATCH = 8'h04;
	localparam logic [7:0] REG_SELECT = 8'h08;
	localparam logic [7:0] REG_SYSCTL = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// enable register: master flag and per source flags
	localparam int IMF_BIT = 0;
	localparam logic [15:0] ENABLE_MASK = 16'hFFF1;
	localparam logic [15:0] ENABLE_RST = 16'h0000;
	localparam logic [15:0] EF_MASK = 16'hFFF0;
	localparam logic [15:0] LATCH_MASK = 16'hFFFC;
	localparam logic [15:0] EXT0_MASK = 16'h0010;

	// select register fields
	localparam int SEL13_BIT = 0;
	localparam int SEL14_BIT = 1;
	localparam int SEL15_BIT = 2;
	localparam int EXT0EN_BIT = 3;
	localparam int RAMTRAP_BIT = 4;
	localparam int TRAPSEL_BIT = 5;
	localparam int WDTSEL_BIT = 6;
	localparam logic [6:0] SELECT_RST = 7'h60;

	// system control fields: both oscillator enables and the clock select
	localparam int HOSC_BIT = 0;
	localparam int LOSC_BIT = 1;
	localparam int CKSEL_BIT = 2;
	localparam logic [2:0] SYSCTL_RST = 3'h1;
	localparam int STAT_REQ_BIT = 16;

	// source indices; vector is the reset vector minus twice the index
	localparam logic [3:0] IDX_NONE = 4'h0;
	localparam logic [3:0] IDX_SOFT = 4'h1;
	localparam logic [3:0] IDX_TRAP = 4'h2;
	localparam logic [3:0] IDX_WDT = 4'h3;
	localparam logic [3:0] IDX_EXT0 = 4'h4;
	localparam int FIRST_MASKABLE = 4;
	localparam int LAST_MASKABLE = 15;
	localparam logic [15:0] RST_VEC = 16'hFFFE;

	// address trap areas
	localparam logic [15:0] SFR_HI = 16'h003F;
	localparam logic [15:0] RAM_LO = 16'h0040;
	localparam logic [15:0] RAM_HI = 16'h083F;

	typedef enum {RAI_RUN, RAI_EXT, RAI_MALF} rai_rst_state_type;
endpackage

// *** rai_latch_if.sv ***
// interface: pending latch set, clear and state between arbiter parts
`timescale 1ns/1ps
`default_nettype none
interface rai_latch_if;
	logic [15:0] set;
	logic [15:0] clr;
	logic [15:0] q;
	modport ctl (output set, output clr, input q);
	modport bank (input set, input clr, output q);
endinterface
`default_nettype wire

// *** rai_latch_bank.sv ***
// module: bank of pending interrupt latches
`timescale 1ns/1ps
`default_nettype none
module rai_latch_bank (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	rai_latch_if.bank lat
);
	// set beats clear so a request in the clearing cycle is kept
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lat.q <= '0;
		end else if (ce_i) begin
			lat.q <= (lat.q & ~lat.clr) | lat.set;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	property p_latch_set;
		(lat.set != 16'h0000) |=> ((lat.q & $past(lat.set)) == $past(lat.set));
	endproperty
	a_latch_set: assert property (p_latch_set)
		else $error("requested latch not set");

	property p_latch_hold;
		(lat.set == 16'h0000 && lat.clr == 16'h0000) |=> $stable(lat.q);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latch changed without cause");
endmodule
`default_nettype wire

// *** rai_arbiter.sv ***
// module: reset sources and prioritised vectored interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module rai_arbiter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rst_pin_n_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	output logic core_reset_o,
	input wire logic fetch_valid_i,
	input wire logic [15:0] fetch_addr_i,
	input wire logic software_irq_i,
	input wire logic bad_opcode_irq_i,
	input wire logic watchdog_event_i,
	input wire logic ext_irq_0_i,
	input wire logic ext_irq_1_i,
	input wire logic ext_irq_2_i,
	input wire logic ext_irq_3_i,
	input wire logic ext_irq_4_i,
	input wire logic ext_irq_5_i,
	input wire logic time_base_irq_i,
	input wire logic timer1_irq_i,
	input wire logic timer2_irq_i,
	input wire logic timer3_irq_i,
	input wire logic timer4_irq_i,
	input wire logic serial_io_irq_i,
	input wire logic uart_receive_irq_i,
	input wire logic uart_transmit_irq_i,
	input wire logic converter_done_irq_i,
	output logic irq_req_o,
	output logic [15:0] irq_vector_o,
	input wire logic irq_ack_i,
	output logic stacked_imf_o,
	input wire logic reti_i,
	input wire logic reti_imf_i
);
	rai_pkg::rai_rst_state_type state, next_state;
	logic [3:0] ext_cnt;
	logic [4:0] malf_cnt;
	logic [15:0] enable;
	logic [6:0] select;
	logic [2:0] sysctl;
	logic [3:0] idx;
	logic [3:0] next_idx;
	logic ack;
	logic [31:0] rdata;
	// any reset state holds the registers, not only the power reset
	wire logic sys_rst = rst_i | (state != rai_pkg::RAI_RUN);

	rai_latch_if lat ();

	rai_latch_bank u_bank (
		.clk_i(clk_i),
		.rst_i(sys_rst),
		.ce_i(ce_i),
		.lat(lat)
	);

	// bus decode; a word is taken once per cycle/strobe pair
	wire logic bus_go = wb_cyc_i & wb_stb_i & ~ack;
	wire logic wr_go = bus_go & wb_we_i;
	wire logic [7:0] word_adr = {wb_adr_i[7:2], 2'h0};
	wire logic hit_enable = word_adr == rai_pkg::REG_ENABLE;
	wire logic hit_latch = word_adr == rai_pkg::REG_LATCH;
	wire logic hit_select = word_adr == rai_pkg::REG_SELECT;
	wire logic hit_sysctl = word_adr == rai_pkg::REG_SYSCTL;
	wire logic hit_status = word_adr == rai_pkg::REG_STATUS;
	wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// byte lane merge of write data over the old register value
	function automatic logic [31:0] merge(input logic [31:0] old);
		return (old & ~wmask) | (wb_dat_i & wmask);
	endfunction

	wire logic [31:0] en_wr = merge({16'h0000, enable});
	wire logic [31:0] lt_wr = merge({16'h0000, lat.q});
	wire logic [31:0] sl_wr = merge({25'h0000000, select});
	wire logic [31:0] sc_wr = merge({29'h00000000, sysctl});

	// reset sequencing
	wire logic master_enable_flag = enable[rai_pkg::IMF_BIT];
	// our own low drive must not look like an external reset
	wire logic ext_low = ~rst_pin_n_i & ~rst_pin_oe_o;
	wire logic ext_done = ext_low & (ext_cnt == rai_pkg::EXT_CNT_LAST);

	// address trap: sfr area always, ram only when enabled
	wire logic in_sfr = fetch_addr_i <= rai_pkg::SFR_HI; // area starts at 0
	wire logic in_ram = fetch_addr_i >= rai_pkg::RAM_LO &&
		fetch_addr_i <= rai_pkg::RAM_HI;
	wire logic trap_hit = fetch_valid_i &
		(in_sfr | (in_ram & select[rai_pkg::RAMTRAP_BIT]));
	wire logic trap_rst = trap_hit & select[rai_pkg::TRAPSEL_BIT];
	wire logic wdt_rst = watchdog_event_i &
		select[rai_pkg::WDTSEL_BIT];

	// clock deadlock: disabling the running oscillator, or both
	wire logic sc_write = wr_go & hit_sysctl;
	wire logic clr_hi = sysctl[rai_pkg::HOSC_BIT] & ~sc_wr[rai_pkg::HOSC_BIT];
	wire logic clr_lo = sysctl[rai_pkg::LOSC_BIT] & ~sc_wr[rai_pkg::LOSC_BIT];
	wire logic on_low = sysctl[rai_pkg::CKSEL_BIT];
	wire logic dead = sc_write & ((clr_hi & clr_lo) | (clr_hi & ~on_low) |
		(clr_lo & on_low));
	wire logic malf_go = trap_rst | wdt_rst | dead;

	// next reset state
	always_comb begin
		next_state = state;
		case (state)
			rai_pkg::RAI_RUN: begin
				if (malf_go) begin
					next_state = rai_pkg::RAI_MALF;
				end else if (ext_done) begin
					next_state = rai_pkg::RAI_EXT;
				end
			end
			rai_pkg::RAI_EXT: begin
				if (rst_pin_n_i) begin
					next_state = rai_pkg::RAI_RUN;
				end
			end
			rai_pkg::RAI_MALF: begin
				if (malf_cnt == rai_pkg::MALF_CNT_ONE) begin
					next_state = rai_pkg::RAI_RUN;
				end
			end
			default: begin
				next_state = rai_pkg::RAI_RUN;
			end
		endcase
	end

	// reset state and its counters, cleared only by the power reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= rai_pkg::RAI_RUN;
			ext_cnt <= '0;
			malf_cnt <= '0;
		end else if (ce_i) begin
			state <= next_state;
			ext_cnt <= (state == rai_pkg::RAI_RUN && ext_low) ?
				ext_cnt + 4'h1 : 4'h0;
			malf_cnt <= (state == rai_pkg::RAI_MALF) ? malf_cnt - 5'h01 :
				(malf_go ? rai_pkg::MALF_CNT_LOAD : 5'h00);
		end
	end

	assign rst_pin_o = 1'h0;
	assign rst_pin_oe_o = state == rai_pkg::RAI_MALF;
	assign core_reset_o = state != rai_pkg::RAI_RUN;

	// request sources onto latches 2 to 15, shared levels by selector
	assign lat.set = {
		select[rai_pkg::SEL15_BIT] ? converter_done_irq_i : ext_irq_5_i,
		select[rai_pkg::SEL14_BIT] ? uart_transmit_irq_i : ext_irq_4_i,
		select[rai_pkg::SEL13_BIT] ? timer2_irq_i : uart_receive_irq_i,
		serial_io_irq_i, ext_irq_3_i, timer3_irq_i, timer4_irq_i,
		ext_irq_2_i, timer1_irq_i, time_base_irq_i, ext_irq_1_i,
		ext_irq_0_i, watchdog_event_i & ~select[rai_pkg::WDTSEL_BIT],
		trap_hit & ~select[rai_pkg::TRAPSEL_BIT], 2'h0
	};

	// acceptance clears its latch; software writes of 0 clear too
	wire logic ack_take = irq_req_o & irq_ack_i;
	wire logic [15:0] ack_clr = ack_take ? (16'h0001 << idx) : 16'h0000;
	wire logic [15:0] sw_clr = (wr_go & hit_latch) ? ~lt_wr[15:0] : 16'h0000;
	assign lat.clr = (ack_clr | sw_clr) & rai_pkg::LATCH_MASK;

	// candidates: maskable need master, own flag and, for ext0, the EXT0EN select bit
	wire logic soft_nmi = software_irq_i | bad_opcode_irq_i;
	wire logic nmi_any = soft_nmi | lat.q[rai_pkg::IDX_TRAP] |
		lat.q[rai_pkg::IDX_WDT];
	wire logic [15:0] pin_gate = select[rai_pkg::EXT0EN_BIT] ? 16'hFFFF :
		~rai_pkg::EXT0_MASK;
	wire logic [15:0] mask_ok = lat.q & enable & rai_pkg::EF_MASK &
		{16{master_enable_flag}} & pin_gate;

	// lowest index wins; nmi overrides, trap before watchdog before software
	always_comb begin
		next_idx = rai_pkg::IDX_NONE;
		for (int n = rai_pkg::LAST_MASKABLE; n >= rai_pkg::FIRST_MASKABLE;
			n--) begin
			if (mask_ok[n]) begin
				next_idx = 4'(n);
			end
		end
		if (soft_nmi) begin
			next_idx = rai_pkg::IDX_SOFT;
		end
		if (lat.q[rai_pkg::IDX_WDT]) begin
			next_idx = rai_pkg::IDX_WDT;
		end
		if (lat.q[rai_pkg::IDX_TRAP]) begin
			next_idx = rai_pkg::IDX_TRAP;
		end
	end

	// presented request and vector; request drops on its own acceptance
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			irq_req_o <= 1'h0;
			idx <= rai_pkg::IDX_NONE;
			irq_vector_o <= rai_pkg::RST_VEC;
		end else if (ce_i) begin
			irq_req_o <= (next_idx != rai_pkg::IDX_NONE) & ~ack_take;
			idx <= next_idx;
			irq_vector_o <= rai_pkg::RST_VEC -
				{11'h000, next_idx, 1'h0};
		end
	end

	// software registers; acceptance and return win over bus writes
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			enable <= rai_pkg::ENABLE_RST;
			select <= rai_pkg::SELECT_RST;
			sysctl <= rai_pkg::SYSCTL_RST;
		end else if (ce_i) begin
			if (ack_take) begin
				enable[rai_pkg::IMF_BIT] <= 1'h0;
			end else if (reti_i) begin
				enable[rai_pkg::IMF_BIT] <= reti_imf_i;
			end else if (wr_go && hit_enable) begin
				enable <= en_wr[15:0] & rai_pkg::ENABLE_MASK;
			end
			if (wr_go && hit_select) begin
				select <= sl_wr[6:0];
			end
			if (sc_write && !dead) begin
				sysctl <= sc_wr[2:0]; // deadlock write is dropped
			end
		end
	end

	// stacked master flag survives a later fault reset for the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stacked_imf_o <= 1'h0;
		end else if (ce_i && ack_take) begin
			stacked_imf_o <= master_enable_flag;
		end
	end

	// read mux; unmapped words read zero and are still acknowledged
	wire logic [31:0] rd_mux =
		hit_enable ? {16'h0000, enable} :
		hit_latch ? {16'h0000, lat.q & rai_pkg::LATCH_MASK} :
		hit_select ? {25'h0000000, select} :
		hit_sysctl ? {29'h00000000, sysctl} :
		hit_status ? {15'h0000, irq_req_o, irq_vector_o} : 32'h00000000;

	// bus answer one cycle after the strobe, dropped the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'h0;
			rdata <= 32'h00000000;
		end else if (ce_i) begin
			ack <= bus_go;
			rdata <= bus_go ? rd_mux : rdata;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	property p_ext_rst;
		state == rai_pkg::RAI_RUN && ext_done |=> core_reset_o;
	endproperty
	a_ext_rst: assert property (p_ext_rst)
		else $error("pin reset not applied");

	property p_boot_vec;
		$fell(core_reset_o) |-> irq_vector_o == rai_pkg::RST_VEC && !irq_req_o;
	endproperty
	a_boot_vec: assert property (p_boot_vec)
		else $error("boot vector not presented");

	property p_trap_nmi;
		trap_hit && !select[rai_pkg::TRAPSEL_BIT] &&
			next_state == rai_pkg::RAI_RUN |=> lat.q[rai_pkg::IDX_TRAP];
	endproperty
	a_trap_nmi: assert property (p_trap_nmi)
		else $error("trap did not set its latch");

	property p_malf_len;
		$rose(rst_pin_oe_o) |-> rst_pin_oe_o[*8] ##17 !rst_pin_oe_o;
	endproperty
	a_malf_len: assert property (p_malf_len)
		else $error("fault reset length wrong");

	property p_trap_rst;
		state == rai_pkg::RAI_RUN && trap_rst |=> rst_pin_oe_o && core_reset_o;
	endproperty
	a_trap_rst: assert property (p_trap_rst)
		else $error("trap reset not driven");

	property p_dead;
		state == rai_pkg::RAI_RUN && dead |=> rst_pin_oe_o && $stable(sysctl);
	endproperty
	a_dead: assert property (p_dead)
		else $error("deadlock reset missing");

	property p_mask;
		irq_req_o && idx >= rai_pkg::IDX_EXT0 |->
			$past(master_enable_flag) && (($past(enable) & (16'h0001 << idx)) != 16'h0000);
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked source presented");

	property p_prio;
		irq_req_o && idx >= rai_pkg::IDX_EXT0 |-> !$past(nmi_any);
	endproperty
	a_prio: assert property (p_prio)
		else $error("maskable beat a pending nmi");

	property p_clear;
		ack_take && idx >= rai_pkg::IDX_TRAP && !lat.set[idx] && !sys_rst
			|=> !lat.q[$past(idx)];
	endproperty
	a_clear: assert property (p_clear)
		else $error("accepted latch not cleared");

	property p_stack;
		ack_take |=> !master_enable_flag && stacked_imf_o == $past(master_enable_flag);
	endproperty
	a_stack: assert property (p_stack)
		else $error("master flag not stacked");

	property p_wdt;
		watchdog_event_i && !select[rai_pkg::WDTSEL_BIT] &&
			next_state == rai_pkg::RAI_RUN |=> lat.q[rai_pkg::IDX_WDT];
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog nmi not latched");

	c_ext: cover property (state == rai_pkg::RAI_RUN && ext_done);
	c_trap_acc: cover property (ack_take && idx == rai_pkg::IDX_TRAP);
	c_malf: cover property ($rose(rst_pin_oe_o));
	c_mask_acc: cover property (ack_take && idx >= rai_pkg::IDX_EXT0);
endmodule
`default_nettype wire

// *** rai_core_model.sv ***
// partner model: core acceptance, return and the pulled-up reset pin
`timescale 1ns/1ps
`default_nettype none
module rai_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic irq_req_i,
	input wire logic stacked_imf_i,
	input wire logic [3:0] ack_wait_i,
	input wire logic [4:0] pin_low_i,
	input wire logic pin_go_i,
	input wire logic pin_oe_i,
	output logic irq_ack_o,
	output logic reti_o,
	output logic reti_imf_o,
	output logic rst_pin_n_o
);
	logic [3:0] wait_cnt;
	logic [2:0] ret_cnt;
	logic [4:0] low_cnt;

	// pull-up wins unless the device or this model pulls low
	assign rst_pin_n_o = !(pin_oe_i || low_cnt != 5'h00);

	// accept after a chosen wait, return four cycles later
	// no nesting: a second acceptance before return reloads the count
	always_ff @(posedge clk_i) begin
		irq_ack_o <= 1'b0;
		reti_o <= 1'b0;
		if (rst_i) begin
			wait_cnt <= 4'h0;
			ret_cnt <= 3'h0;
			reti_imf_o <= 1'b0;
		end else begin
			if (ret_cnt != 3'h0) begin
				ret_cnt <= ret_cnt - 3'h1;
				reti_o <= ret_cnt == 3'h1;
				reti_imf_o <= stacked_imf_i;
			end
			if (irq_req_i && !irq_ack_o) begin
				if (wait_cnt >= ack_wait_i) begin
					irq_ack_o <= 1'b1;
					wait_cnt <= 4'h0;
					ret_cnt <= 3'h4;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end

	// pin held low for the commanded number of edges
	always_ff @(posedge clk_i) begin
		if (rst_i)
			low_cnt <= 5'h00;
		else if (pin_go_i)
			low_cnt <= pin_low_i;
		else if (low_cnt != 5'h00)
			low_cnt <= low_cnt - 5'h01;
	end
endmodule
`default_nettype wire

// *** rai_arbiter_tb_top.sv ***
// testbench: reset and interrupt arbiter against the core model
`timescale 1ns/1ps
`default_nettype none
module rai_arbiter_tb_top;
	logic clk = 0, rst = 1, cyc = 0, we = 0, fv = 0, sw = 0, bad = 0;
	logic ce = 1;
	logic [3:0] sel = 4'hF;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [15:0] fa = 16'h0000, src = 16'h0000, vec;
	logic [2:0] alt = 3'h0;
	logic [3:0] ack_wait = 4'h0;
	logic [4:0] pin_low = 5'h00;
	logic pin_go = 0, bak, ack, req, reti, reti_imf, simf, pin_n, oe, crst;
	int err_count = 0, samples_checked = 0;
	logic [31:0] dq[$];
	logic [15:0] vq[$];

	rai_arbiter i_rai_arbiter (.clk_i(clk), .rst_i(rst), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(bak),
		.rst_pin_n_i(pin_n), .rst_pin_o(), .rst_pin_oe_o(oe),
		.core_reset_o(crst), .fetch_valid_i(fv), .fetch_addr_i(fa),
		.software_irq_i(sw), .bad_opcode_irq_i(bad),
		.watchdog_event_i(src[3]), .ext_irq_0_i(src[4]),
		.ext_irq_1_i(src[5]), .ext_irq_2_i(src[8]), .ext_irq_3_i(src[11]),
		.ext_irq_4_i(src[14]), .ext_irq_5_i(src[15]),
		.time_base_irq_i(src[6]), .timer1_irq_i(src[7]),
		.timer2_irq_i(alt[0]), .timer3_irq_i(src[10]),
		.timer4_irq_i(src[9]), .serial_io_irq_i(src[12]),
		.uart_receive_irq_i(src[13]), .uart_transmit_irq_i(alt[1]),
		.converter_done_irq_i(alt[2]), .irq_req_o(req),
		.irq_vector_o(vec), .irq_ack_i(ack), .stacked_imf_o(simf),
		.reti_i(reti), .reti_imf_i(reti_imf));

	rai_core_model i_rai_core_model (.clk_i(clk), .rst_i(rst),
		.irq_req_i(req), .stacked_imf_i(simf), .ack_wait_i(ack_wait),
		.pin_low_i(pin_low), .pin_go_i(pin_go), .pin_oe_i(oe),
		.irq_ack_o(ack), .reti_o(reti), .reti_imf_o(reti_imf),
		.rst_pin_n_o(pin_n));

	// 250 MHz fc clock
	initial forever #2 clk = ~clk;

	// compare helpers, every comparison counted
	task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: vector %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: %s %0d expected %0d", $time, what, got, exp);
		end
	endtask

	function automatic logic [15:0] v(input int n);
		return 16'hFFFE - 16'(2 * n);
	endfunction

	// oldest note against each read return and each accepted vector
	always @(posedge clk) begin
		if (bak === 1'b1 && we === 1'b0)
			chk_dat(rdat, dq.size() ? dq.pop_front() : 32'hXXXXXXXX);
		if (ack === 1'b1 && req === 1'b1) begin
			chk_vec(vec, vq.size() ? vq.pop_front() : 16'hXXXX);
			if (vec === 16'hFFFC) begin
				sw <= 1'b0;
				bad <= 1'b0;
			end
		end
	end

	// classic cycle: held until ack, a read notes its expected word
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		if (!w)
			dq.push_back(d);
		do begin
			@(posedge clk);
			n++;
		end while (bak !== 1'b1 && n < 20);
		cyc <= 1'b0;
		if (n >= 20)
			chk_val(0, 1, "bus ack");
	endtask
	task automatic pulse(input logic [15:0] s, input logic [2:0] a);
		@(posedge clk);
		src <= s;
		alt <= a;
		@(posedge clk);
		src <= 16'h0000;
		alt <= 3'h0;
	endtask
	task automatic fetch(input logic [15:0] a);
		@(posedge clk);
		fv <= 1'b1;
		fa <= a;
		@(posedge clk);
		fv <= 1'b0;
	endtask
	task automatic pin(input logic [4:0] len);
		@(posedge clk);
		pin_low <= len;
		pin_go <= 1'b1;
		@(posedge clk);
		pin_go <= 1'b0;
	endtask
	// let acceptances drain; every noted vector must have come
	task automatic settle();
		repeat (40) @(posedge clk);
		chk_val(vq.size(), 0, "pending");
	endtask
	// cycles of core reset and of pin drive in a fixed window
	task automatic rst_chk(input int exp, input int exp_oe);
		int n;
		int k;
		n = 0;
		k = 0;
		repeat (60) begin
			@(posedge clk);
			n += int'(crst === 1'b1);
			k += int'(oe === 1'b1);
		end
		chk_val(n, exp, "reset cycles");
		chk_val(k, exp_oe, "pin drive cycles");
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// hang guard: run needs about 1600 cycles, allow 20000
	initial begin
		#80000;
		err_count++;
		final_report();
	end

	initial begin
		int a;
		int b;
		int n;
		void'($urandom(19));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// reset values and an unmapped word
		bus(0, rai_pkg::REG_ENABLE, 32'h0);
		bus(0, rai_pkg::REG_LATCH, 32'h0);
		bus(0, rai_pkg::REG_SELECT, 32'h60);
		bus(0, rai_pkg::REG_SYSCTL, 32'h1);
		bus(0, rai_pkg::REG_STATUS, 32'h0000FFFE);
		bus(0, 8'h14, 32'h0);
		// only the low byte lane lands: master flag and sources 7:4
		sel <= 4'h1;
		bus(1, rai_pkg::REG_ENABLE, 32'hFFF1);
		sel <= 4'hF;
		bus(0, rai_pkg::REG_ENABLE, 32'h00F1);
		// clock enable low: a request pulse is not latched
		ce <= 1'b0;
		pulse(16'h0080, 3'h0);
		repeat (5) @(posedge clk);
		ce <= 1'b1;
		repeat (5) @(posedge clk);
		chk_val(req, 0, "frozen request");
		$display("test reset_values done");
		// each maskable level alone, random core response time
		bus(1, rai_pkg::REG_SELECT, 32'h68);
		for (n = 4; n < 16; n++) begin
			ack_wait <= 4'($urandom % 8);
			bus(1, rai_pkg::REG_ENABLE, 32'h1 | (32'h1 << n));
			vq.push_back(v(n));
			pulse(16'h1 << n, 3'h0);
			settle();
		end
		// shared levels: alternate ignored until selected
		for (n = 13; n < 16; n++) begin
			bus(1, rai_pkg::REG_ENABLE, 32'h1 | (32'h1 << n));
			bus(1, rai_pkg::REG_SELECT, 32'h68);
			pulse(16'h0000, 3'h1 << (n - 13));
			settle();
			bus(1, rai_pkg::REG_SELECT, 32'h68 | (32'h1 << (n - 13)));
			vq.push_back(v(n));
			pulse(16'h0000, 3'h1 << (n - 13));
			settle();
		end
		$display("test maskable_levels done");
		// master flag low holds the latched request back
		bus(1, rai_pkg::REG_SELECT, 32'h68);
		bus(1, rai_pkg::REG_ENABLE, 32'h80);
		pulse(16'h0080, 3'h0);
		repeat (20) @(posedge clk);
		chk_val(req, 0, "masked request");
		vq.push_back(16'hFFF0);
		bus(1, rai_pkg::REG_ENABLE, 32'h81);
		settle();
		// two levels at once: lower first, other after return
		bus(1, rai_pkg::REG_ENABLE, 32'hFFF1);
		a = 4 + $urandom % 12;
		b = 4 + (a - 3 + $urandom % 11) % 12;
		vq.push_back(v(a < b ? a : b));
		vq.push_back(v(a < b ? b : a));
		pulse((16'h1 << a) | (16'h1 << b), 3'h0);
		settle();
		$display("test masking_and_priority done");
		// watchdog and trap as interrupts, soft sources held
		bus(1, rai_pkg::REG_SELECT, 32'h08);
		vq.push_back(16'hFFF8);
		vq.push_back(16'hFFF0);
		pulse(16'h0088, 3'h0);
		settle();
		bus(1, rai_pkg::REG_ENABLE, 32'h0);
		vq.push_back(16'hFFFA);
		fetch(16'h0010);
		settle();
		fetch(16'h0100);
		settle();
		bus(1, rai_pkg::REG_SELECT, 32'h18);
		vq.push_back(16'hFFFA);
		fetch(16'h0100);
		settle();
		vq.push_back(16'hFFFC);
		sw <= 1'b1;
		settle();
		vq.push_back(16'hFFFC);
		bad <= 1'b1;
		settle();
		$display("test non_maskable done");
		// fault resets with default selects
		bus(1, rai_pkg::REG_SELECT, 32'h60);
		fetch(16'h003F);
		rst_chk(24, 24);
		pulse(16'h0008, 3'h0);
		rst_chk(24, 24);
		bus(1, rai_pkg::REG_SYSCTL, 32'h0);
		// the first fault cycle is the ack cycle, before the window
		rst_chk(23, 23);
		bus(1, rai_pkg::REG_SYSCTL, 32'h7);
		bus(0, rai_pkg::REG_SYSCTL, 32'h7);
		bus(1, rai_pkg::REG_SYSCTL, 32'h5);
		rst_chk(23, 23);
		$display("test fault_resets done");
		// pin one edge short is ignored, a longer hold resets
		bus(1, rai_pkg::REG_ENABLE, 32'hFFF1);
		pin(5'h0B);
		rst_chk(0, 0);
		pin(5'h10);
		rst_chk(5, 0);
		bus(0, rai_pkg::REG_ENABLE, 32'h0);
		bus(0, rai_pkg::REG_STATUS, 32'h0000FFFE);
		$display("test pin_reset done");
		final_report();
	end
endmodule
`default_nettype wire
